//--- logic/psalu_core.sv
// packed integer simd datapath with eight 64-bit registers
// assumes the decoder gives one request a cycle, memory and gpr data ready
`timescale 1ns/1ps
module psalu_core
    import psalu_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    nrst_i,
    // request from the decoder
    input  wire psalu_pkg::psalu_req_type req_i,
    input  wire logic [63:0]             mem_data_i,
    input  wire logic [31:0]             gpr_data_i,
    // result
    output psalu_pkg::psalu_rsp_type     rsp_o
);
    import psalu_pkg::*;

    logic [63:0]   regs_q [PSALU_NREG];
    logic [63:0]   a;
    logic [63:0]   b;
    logic [63:0]   res;
    logic          wr_reg;
    logic [63:0]   c_add_b, c_sub_b, c_adds_b, c_subs_b, c_addu_b, c_subu_b;
    logic [63:0]   c_ceq_b, c_cgt_b;
    logic [63:0]   c_add_w, c_sub_w, c_adds_w, c_subs_w, c_addu_w, c_subu_w;
    logic [63:0]   c_ceq_w, c_cgt_w, c_mulh, c_mull, c_sll_w, c_srl_w, c_sra_w;
    logic [63:0]   c_add_d, c_sub_d, c_ceq_d, c_cgt_d, c_sll_d, c_srl_d, c_sra_d;
    logic [63:0]   c_madd;
    logic [63:0]   cnt;
    psalu_rsp_type rsp_q;

    assign a = regs_q[req_i.dst];
    // second operand source
    always_comb
    begin
        case (req_i.src)
            PSALU_SRC_MEM: b = mem_data_i;
            PSALU_SRC_GPR: b = {32'h0000_0000, gpr_data_i};
            default:       b = regs_q[req_i.srcb];
        endcase
    end
    assign cnt = b;

    // byte lanes
    genvar i;
    for (i = 0; i < 8; i++)
    begin : g_byte
        logic [8:0] s, d;
        logic signed [8:0] ss, sd;
        assign s  = {1'b0, a[8*i+:8]} + {1'b0, b[8*i+:8]};
        assign d  = {1'b0, a[8*i+:8]} - {1'b0, b[8*i+:8]};
        assign ss = $signed({a[8*i+7], a[8*i+:8]}) + $signed({b[8*i+7], b[8*i+:8]});
        assign sd = $signed({a[8*i+7], a[8*i+:8]}) - $signed({b[8*i+7], b[8*i+:8]});
        assign c_add_b[8*i+:8] = s[7:0];
        assign c_sub_b[8*i+:8] = d[7:0];
        assign c_adds_b[8*i+:8] = (ss > 9'sd127) ? 8'h7f :
                                  (ss < -9'sd128) ? 8'h80 : ss[7:0];
        assign c_subs_b[8*i+:8] = (sd > 9'sd127) ? 8'h7f :
                                  (sd < -9'sd128) ? 8'h80 : sd[7:0];
        assign c_addu_b[8*i+:8] = s[8] ? 8'hff : s[7:0];
        assign c_subu_b[8*i+:8] = d[8] ? 8'h00 : d[7:0];
        assign c_ceq_b[8*i+:8] = {8{a[8*i+:8] == b[8*i+:8]}};
        assign c_cgt_b[8*i+:8] = {8{$signed(a[8*i+:8]) > $signed(b[8*i+:8])}};
    end

    // word lanes
    for (i = 0; i < 4; i++)
    begin : g_word
        logic [16:0] s, d;
        logic signed [16:0] ss, sd;
        logic signed [31:0] p;
        assign s  = {1'b0, a[16*i+:16]} + {1'b0, b[16*i+:16]};
        assign d  = {1'b0, a[16*i+:16]} - {1'b0, b[16*i+:16]};
        assign ss = $signed({a[16*i+15], a[16*i+:16]}) + $signed({b[16*i+15], b[16*i+:16]});
        assign sd = $signed({a[16*i+15], a[16*i+:16]}) - $signed({b[16*i+15], b[16*i+:16]});
        assign p  = $signed(a[16*i+:16]) * $signed(b[16*i+:16]);
        assign c_add_w[16*i+:16] = s[15:0];
        assign c_sub_w[16*i+:16] = d[15:0];
        assign c_adds_w[16*i+:16] = (ss > 17'sd32767) ? 16'h7fff :
                                    (ss < -17'sd32768) ? 16'h8000 : ss[15:0];
        assign c_subs_w[16*i+:16] = (sd > 17'sd32767) ? 16'h7fff :
                                    (sd < -17'sd32768) ? 16'h8000 : sd[15:0];
        assign c_addu_w[16*i+:16] = s[16] ? 16'hffff : s[15:0];
        assign c_subu_w[16*i+:16] = d[16] ? 16'h0000 : d[15:0];
        assign c_mulh[16*i+:16] = p[31:16];
        assign c_mull[16*i+:16] = p[15:0];
        assign c_ceq_w[16*i+:16] = {16{a[16*i+:16] == b[16*i+:16]}};
        assign c_cgt_w[16*i+:16] = {16{$signed(a[16*i+:16]) > $signed(b[16*i+:16])}};
        // oversize counts saturate to zero or sign fill
        assign c_sll_w[16*i+:16] = (cnt > 64'd15) ? 16'h0000 : a[16*i+:16] << cnt[3:0];
        assign c_srl_w[16*i+:16] = (cnt > 64'd15) ? 16'h0000 : a[16*i+:16] >> cnt[3:0];
        assign c_sra_w[16*i+:16] = $signed(a[16*i+:16]) >>> ((cnt > 64'd15) ? 4'd15 : cnt[3:0]);
    end

    // dword lanes
    for (i = 0; i < 2; i++)
    begin : g_dword
        logic signed [31:0] p0, p1;
        assign p0 = $signed(a[32*i+:16]) * $signed(b[32*i+:16]);
        assign p1 = $signed(a[32*i+16+:16]) * $signed(b[32*i+16+:16]);
        assign c_madd[32*i+:32] = p0 + p1;
        assign c_add_d[32*i+:32] = a[32*i+:32] + b[32*i+:32];
        assign c_sub_d[32*i+:32] = a[32*i+:32] - b[32*i+:32];
        assign c_ceq_d[32*i+:32] = {32{a[32*i+:32] == b[32*i+:32]}};
        assign c_cgt_d[32*i+:32] = {32{$signed(a[32*i+:32]) > $signed(b[32*i+:32])}};
        assign c_sll_d[32*i+:32] = (cnt > 64'd31) ? 32'h0 : a[32*i+:32] << cnt[4:0];
        assign c_srl_d[32*i+:32] = (cnt > 64'd31) ? 32'h0 : a[32*i+:32] >> cnt[4:0];
        assign c_sra_d[32*i+:32] = $signed(a[32*i+:32]) >>> ((cnt > 64'd31) ? 5'd31 : cnt[4:0]);
    end

    function automatic logic [7:0] sat_sb(input logic [15:0] w);
        if ($signed(w) > 16'sd127)
            return 8'h7f;
        else if ($signed(w) < -16'sd128)
            return 8'h80;
        return w[7:0];
    endfunction : sat_sb

    function automatic logic [7:0] sat_ub(input logic [15:0] w);
        if (w[15])
            return 8'h00;
        else if (w > 16'h00ff)
            return 8'hff;
        return w[7:0];
    endfunction : sat_ub

    function automatic logic [15:0] sat_sw(input logic [31:0] d);
        if ($signed(d) > 32'sd32767)
            return 16'h7fff;
        else if ($signed(d) < -32'sd32768)
            return 16'h8000;
        return d[15:0];
    endfunction : sat_sw

    // result select; a is destination (first source), b second source
    always_comb
    begin
        res    = a;
        wr_reg = 1'b1;
        case (req_i.op)
            // moves: dword zero-extends, quad moves whole
            PSALU_MOVE_DWORD: res = (req_i.to_gpr || req_i.to_mem) ? {32'h0, a[31:0]}
                                                                   : {32'h0, b[31:0]};
            PSALU_MOVE_QUAD:  res = (req_i.to_gpr || req_i.to_mem) ? a : b;
            // low half from first source, high half from second
            PSALU_PACK_SSWB: res = {sat_sb(b[63:48]), sat_sb(b[47:32]), sat_sb(b[31:16]),
                                    sat_sb(b[15:0]), sat_sb(a[63:48]), sat_sb(a[47:32]),
                                    sat_sb(a[31:16]), sat_sb(a[15:0])};
            PSALU_PACK_USWB: res = {sat_ub(b[63:48]), sat_ub(b[47:32]), sat_ub(b[31:16]),
                                    sat_ub(b[15:0]), sat_ub(a[63:48]), sat_ub(a[47:32]),
                                    sat_ub(a[31:16]), sat_ub(a[15:0])};
            PSALU_PACK_SSDW: res = {sat_sw(b[63:32]), sat_sw(b[31:0]),
                                    sat_sw(a[63:32]), sat_sw(a[31:0])};
            PSALU_ILV_LB: res = {b[31:24], a[31:24], b[23:16], a[23:16],
                                 b[15:8], a[15:8], b[7:0], a[7:0]};
            PSALU_ILV_HB: res = {b[63:56], a[63:56], b[55:48], a[55:48],
                                 b[47:40], a[47:40], b[39:32], a[39:32]};
            PSALU_ILV_LW: res = {b[31:16], a[31:16], b[15:0], a[15:0]};
            PSALU_ILV_HW: res = {b[63:48], a[63:48], b[47:32], a[47:32]};
            PSALU_ILV_LD: res = {b[31:0], a[31:0]};
            PSALU_ILV_HD: res = {b[63:32], a[63:32]};
            PSALU_ADD_B:   res = c_add_b;
            PSALU_ADD_W:   res = c_add_w;
            PSALU_ADD_D:   res = c_add_d;
            PSALU_ADDS_B:  res = c_adds_b;
            PSALU_ADDS_W:  res = c_adds_w;
            PSALU_ADDUS_B: res = c_addu_b;
            PSALU_ADDUS_W: res = c_addu_w;
            PSALU_SUB_B:   res = c_sub_b;
            PSALU_SUB_W:   res = c_sub_w;
            PSALU_SUB_D:   res = c_sub_d;
            PSALU_SUBS_B:  res = c_subs_b;
            PSALU_SUBS_W:  res = c_subs_w;
            PSALU_SUBUS_B: res = c_subu_b;
            PSALU_SUBUS_W: res = c_subu_w;
            PSALU_MULH_W:  res = c_mulh;
            PSALU_MULL_W:  res = c_mull;
            PSALU_MADD_W:  res = c_madd;
            PSALU_CEQ_B:   res = c_ceq_b;
            PSALU_CEQ_W:   res = c_ceq_w;
            PSALU_CEQ_D:   res = c_ceq_d;
            PSALU_CGT_B:   res = c_cgt_b;
            PSALU_CGT_W:   res = c_cgt_w;
            PSALU_CGT_D:   res = c_cgt_d;
            PSALU_AND:     res = a & b;
            PSALU_ANDN:    res = ~a & b;
            PSALU_OR:      res = a | b;
            PSALU_XOR:     res = a ^ b;
            PSALU_SLL_W:   res = c_sll_w;
            PSALU_SLL_D:   res = c_sll_d;
            PSALU_SLL_Q:   res = (cnt > 64'd63) ? 64'h0 : a << cnt[5:0];
            PSALU_SRL_W:   res = c_srl_w;
            PSALU_SRL_D:   res = c_srl_d;
            PSALU_SRL_Q:   res = (cnt > 64'd63) ? 64'h0 : a >> cnt[5:0];
            PSALU_SRA_W:   res = c_sra_w;
            PSALU_SRA_D:   res = c_sra_d;
            PSALU_CLEAR:   res = PSALU_REG_RST;
            default:       wr_reg = 1'b0;
        endcase
        // a store-direction move leaves the register file alone
        if ((req_i.op == PSALU_MOVE_DWORD || req_i.op == PSALU_MOVE_QUAD) &&
            (req_i.to_gpr || req_i.to_mem))
            wr_reg = 1'b0;
    end

    // register file
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            for (int k = 0; k < PSALU_NREG; k++)
                regs_q[k] <= PSALU_REG_RST;
        end
        else if (req_i.valid && req_i.op == PSALU_CLEAR)
        begin
            for (int k = 0; k < PSALU_NREG; k++)
                regs_q[k] <= PSALU_REG_RST;
        end
        else if (req_i.valid && wr_reg)
            regs_q[req_i.dst] <= res;
    end

    // registered result
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid  <= req_i.valid;
            rsp_q.to_gpr <= req_i.valid && req_i.to_gpr;
            rsp_q.to_mem <= req_i.valid && req_i.to_mem;
            rsp_q.data   <= res;
        end
    end
    assign rsp_o = rsp_q;

    a_clear_all: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_CLEAR |=> regs_q[0] == 64'h0 && regs_q[7] == 64'h0)
        else $error("clear left register contents");
    a_add_wrap: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_ADD_B
        |=> rsp_o.data[7:0] == 8'($past(a[7:0]) + $past(b[7:0])))
        else $error("byte add did not wrap");
    // both lanes at or above half range always overflow, so the clamp must show
    a_addus_sat: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_ADDUS_B && a[47] && b[47]
        |=> rsp_o.data[47:40] == 8'hff)
        else $error("unsigned add not clamped");
    a_adds_sat: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_ADDS_W && !a[63] && !b[63] && a[62:56] == 7'h7f && b[56]
        |=> rsp_o.data[63:48] == 16'h7fff)
        else $error("signed add not clamped");
    a_cmp_ones: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_CEQ_D && a == b |=> rsp_o.data == 64'hffff_ffff_ffff_ffff)
        else $error("equal compare not all ones");
    a_ceq_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_CEQ_W && a[63:48] != b[63:48]
        |=> rsp_o.data[63:48] == 16'h0000)
        else $error("unequal word compare not all zeros");
    a_shift_big: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_SRL_W && cnt > 64'd15 |=> rsp_o.data == 64'h0)
        else $error("oversize logical shift not zero");
    a_sra_fill: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_SRA_D && cnt > 64'd31
        |=> rsp_o.data == {{32{$past(a[63])}}, {32{$past(a[31])}}})
        else $error("oversize arithmetic shift not sign filled");
    a_and_quad: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_AND |=> rsp_o.data == ($past(a) & $past(b)))
        else $error("quad and wrong");
    a_ilv_low: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid && req_i.op == PSALU_ILV_LD |=> rsp_o.data == {$past(b[31:0]), $past(a[31:0])})
        else $error("low dword interleave wrong");
    a_rsp_valid: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        req_i.valid |=> rsp_o.valid)
        else $error("result valid missing");

    c_madd_seen: cover property (@(posedge mclk_i) req_i.valid && req_i.op == PSALU_MADD_W);
    c_pack_seen: cover property (@(posedge mclk_i) req_i.valid && req_i.op == PSALU_PACK_SSWB);
    c_clear_seen: cover property (@(posedge mclk_i) req_i.valid && req_i.op == PSALU_CLEAR);
    c_store_seen: cover property (@(posedge mclk_i) rsp_o.valid && rsp_o.to_mem);
endmodule : psalu_core

//--- logic/psalu_pkg.sv
// package for the packed integer simd datapath: operations, sources, carriers
// assumes a single core clock; operands arrive already decoded
package psalu_pkg;

    localparam int PSALU_NREG      = 8;
    localparam int PSALU_REG_AW    = 3;
    localparam logic [63:0] PSALU_REG_RST = 64'h0000_0000_0000_0000;

    typedef enum logic [5:0] {
        PSALU_NOP,
        PSALU_MOVE_DWORD, PSALU_MOVE_QUAD,
        PSALU_PACK_SSWB, PSALU_PACK_SSDW, PSALU_PACK_USWB,
        PSALU_ILV_HB, PSALU_ILV_HW, PSALU_ILV_HD,
        PSALU_ILV_LB, PSALU_ILV_LW, PSALU_ILV_LD,
        PSALU_ADD_B, PSALU_ADD_W, PSALU_ADD_D,
        PSALU_ADDS_B, PSALU_ADDS_W, PSALU_ADDUS_B, PSALU_ADDUS_W,
        PSALU_SUB_B, PSALU_SUB_W, PSALU_SUB_D,
        PSALU_SUBS_B, PSALU_SUBS_W, PSALU_SUBUS_B, PSALU_SUBUS_W,
        PSALU_MULH_W, PSALU_MULL_W, PSALU_MADD_W,
        PSALU_CEQ_B, PSALU_CEQ_W, PSALU_CEQ_D,
        PSALU_CGT_B, PSALU_CGT_W, PSALU_CGT_D,
        PSALU_AND, PSALU_ANDN, PSALU_OR, PSALU_XOR,
        PSALU_SLL_W, PSALU_SLL_D, PSALU_SLL_Q,
        PSALU_SRL_W, PSALU_SRL_D, PSALU_SRL_Q,
        PSALU_SRA_W, PSALU_SRA_D,
        PSALU_CLEAR
    } psalu_op_type;

    // where the second operand comes from
    typedef enum logic [1:0] {
        PSALU_SRC_REG,
        PSALU_SRC_MEM,
        PSALU_SRC_GPR
    } psalu_src_type;

    typedef struct packed {
        logic                    valid;
        psalu_op_type            op;
        psalu_src_type           src;
        logic [PSALU_REG_AW-1:0] dst;
        logic [PSALU_REG_AW-1:0] srcb;
        logic                    to_gpr;
        logic                    to_mem;
    } psalu_req_type;

    typedef struct packed {
        logic        valid;
        logic        to_gpr;
        logic        to_mem;
        logic [63:0] data;
    } psalu_rsp_type;

endpackage : psalu_pkg

//--- verif/psalu_lsu_model.sv
// load/store and register-path model at the datapath's far side
// assumes the bench drives requests on the falling edge of the core clock
`timescale 1ns/1ps
module psalu_lsu_model
    import psalu_pkg::*;
(
    // clock
    input  wire logic                     mclk_i,
    // traffic seen at the datapath
    input  wire psalu_pkg::psalu_req_type req_i,
    input  wire psalu_pkg::psalu_rsp_type rsp_i,
    // values the bench wants presented
    input  wire logic [63:0]              mem_val_i,
    input  wire logic [31:0]              gpr_val_i,
    // operand buses and last stored quadword
    output logic [63:0]                   mem_data_o,
    output logic [31:0]                   gpr_data_o,
    output logic [63:0]                   store_o
);
    logic [63:0] noise_q = 64'h5a5a_c3c3_0ff0_a5a5;

    // an unselected bus keeps changing, so a stale operand never passes as a match
    // plain always: the start value comes from the declaration
    always @(posedge mclk_i)
    begin
        noise_q <= ~noise_q;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rsp_i.valid && rsp_i.to_mem)
            store_o <= rsp_i.data;
    end

    assign mem_data_o = (req_i.valid && req_i.src == PSALU_SRC_MEM) ? mem_val_i : noise_q;
    assign gpr_data_o = (req_i.valid && req_i.src == PSALU_SRC_GPR) ? gpr_val_i : ~noise_q[31:0];
endmodule : psalu_lsu_model

//--- verif/tb.sv
// bench for the packed integer datapath: a table of lane operations, then hand tests
// assumes psalu_pkg, psalu_core and psalu_lsu_model are compiled before it
`timescale 1ns/1ps
module tb;
    import psalu_pkg::*;

    typedef struct packed {
        psalu_op_type op;
        logic [63:0]  a;
        logic [63:0]  b;
        logic [63:0]  exp;
    } psalu_row_type;

    localparam logic [63:0] va = 64'h7f01_8000_00ff_1234;
    localparam logic [63:0] vb = 64'h0102_8001_ff01_1234;
    localparam logic [63:0] vc = 64'h0102_0180_ff01_1234;
    localparam logic [63:0] vn = 64'h8000_0000_ffff_fff0;
    localparam logic [63:0] vk = 64'hfedc_ba98_7654_3210;

    logic          mclk;
    logic          rst_n;
    psalu_req_type req;
    psalu_rsp_type rsp;
    psalu_rsp_type last;
    logic [63:0]   mem_data;
    logic [63:0]   mem_val;
    logic [63:0]   store;
    logic [31:0]   gpr_data;
    logic [31:0]   gpr_val;
    int            err_total;
    int            tests_run;

    psalu_row_type rows [0:51] = '{
        '{PSALU_MOVE_QUAD,  va, vb, vb},
        '{PSALU_MOVE_DWORD, va, vb, 64'h0000_0000_ff01_1234},
        '{PSALU_PACK_SSWB,  va, vb, 64'h7f80_807f_7f80_7f7f},
        '{PSALU_PACK_SSDW,  va, vb, 64'h7fff_8000_7fff_7fff},
        '{PSALU_PACK_USWB,  va, vb, 64'hff00_00ff_ff00_ffff},
        '{PSALU_ILV_HB,     va, vb, 64'h017f_0201_8080_0100},
        '{PSALU_ILV_HW,     va, vb, 64'h0102_7f01_8001_8000},
        '{PSALU_ILV_HD,     va, vb, 64'h0102_8001_7f01_8000},
        '{PSALU_ILV_LB,     va, vb, 64'hff00_01ff_1212_3434},
        '{PSALU_ILV_LW,     va, vb, 64'hff01_00ff_1234_1234},
        '{PSALU_ILV_LD,     va, vb, 64'hff01_1234_00ff_1234},
        '{PSALU_ADD_B,      va, vb, 64'h8003_0001_ff00_2468},
        '{PSALU_ADD_W,      va, vb, 64'h8003_0001_0000_2468},
        '{PSALU_ADD_D,      va, vb, 64'h8004_0001_0000_2468},
        '{PSALU_ADDS_B,     va, vb, 64'h7f03_8001_ff00_2468},
        '{PSALU_ADDS_W,     va, vb, 64'h7fff_8000_0000_2468},
        '{PSALU_ADDUS_B,    va, vb, 64'h8003_ff01_ffff_2468},
        '{PSALU_ADDUS_W,    va, vb, 64'h8003_ffff_ffff_2468},
        '{PSALU_SUB_B,      va, vc, 64'h7eff_7f80_01fe_0000},
        '{PSALU_SUB_W,      va, vc, 64'h7dff_7e80_01fe_0000},
        '{PSALU_SUB_D,      va, vc, 64'h7dff_7e80_01fe_0000},
        '{PSALU_SUBS_B,     va, vc, 64'h7eff_807f_01fe_0000},
        '{PSALU_SUBS_W,     va, vc, 64'h7dff_8000_01fe_0000},
        '{PSALU_SUBUS_B,    va, vc, 64'h7e00_7f00_00fe_0000},
        '{PSALU_SUBUS_W,    va, vc, 64'h7dff_7e80_0000_0000},
        '{PSALU_MULH_W,     va, vb, 64'h007f_3fff_ffff_014b},
        '{PSALU_MULL_W,     va, vb, 64'hff02_8000_01ff_5a90},
        '{PSALU_MADD_W,     va, vb, 64'h407f_7f02_014a_5c8f},
        '{PSALU_CEQ_B,      va, vb, 64'h0000_ff00_0000_ffff},
        '{PSALU_CEQ_W,      va, vb, 64'h0000_0000_0000_ffff},
        '{PSALU_CEQ_D,      va, va, 64'hffff_ffff_ffff_ffff},
        '{PSALU_CGT_B,      va, vb, 64'hff00_0000_ff00_0000},
        '{PSALU_CGT_W,      va, vb, 64'hffff_0000_ffff_0000},
        '{PSALU_CGT_D,      va, vb, 64'hffff_ffff_ffff_ffff},
        '{PSALU_AND,        va, vb, 64'h0100_8000_0001_1234},
        '{PSALU_ANDN,       va, vb, 64'h0002_0001_ff00_0000},
        '{PSALU_OR,         va, vb, 64'h7f03_8001_ffff_1234},
        '{PSALU_XOR,        va, vb, 64'h7e03_0001_fffe_0000},
        '{PSALU_SLL_W,      va, 64'h4, 64'hf010_0000_0ff0_2340},
        '{PSALU_SLL_W,      va, 64'hf, 64'h8000_0000_8000_0000},
        '{PSALU_SLL_D,      va, 64'h4, 64'hf018_0000_0ff1_2340},
        '{PSALU_SLL_D,      va, 64'h20, 64'h0},
        '{PSALU_SLL_Q,      va, 64'h8, 64'h0180_0000_ff12_3400},
        '{PSALU_SRL_W,      va, 64'h4, 64'h07f0_0800_000f_0123},
        '{PSALU_SRL_W,      va, 64'h10, 64'h0},
        '{PSALU_SRL_D,      va, 64'h4, 64'h07f0_1800_000f_f123},
        '{PSALU_SRL_Q,      va, 64'h8, 64'h007f_0180_0000_ff12},
        '{PSALU_SRL_Q,      vn, 64'h40, 64'h0},
        '{PSALU_SRA_W,      va, 64'h4, 64'h07f0_f800_000f_0123},
        '{PSALU_SRA_W,      va, 64'h10, 64'h0000_ffff_0000_0000},
        '{PSALU_SRA_D,      vn, 64'h4, 64'hf800_0000_ffff_ffff},
        '{PSALU_SRA_D,      vn, 64'h28, 64'hffff_ffff_ffff_ffff}
    };

    psalu_core uut (.mclk_i(mclk), .nrst_i(rst_n), .req_i(req), .mem_data_i(mem_data),
                    .gpr_data_i(gpr_data), .rsp_o(rsp));
    psalu_lsu_model lsu (.mclk_i(mclk), .req_i(req), .rsp_i(rsp), .mem_val_i(mem_val),
                         .gpr_val_i(gpr_val), .mem_data_o(mem_data), .gpr_data_o(gpr_data),
                         .store_o(store));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic psalu_rsp_type resp(input logic [63:0] d, input logic g, input logic m);
        resp = '{valid: 1'b1, to_gpr: g, to_mem: m, data: d};
    endfunction : resp

    task automatic check(input psalu_rsp_type seen, input psalu_rsp_type want);
        tests_run++;
        if (seen !== want)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // samples the answer to the previous request, then issues the next one
    task automatic go(input psalu_op_type op, input psalu_src_type src, input logic [2:0] dst,
                      input logic [2:0] srcb, input logic tg, input logic tm,
                      input logic [63:0] md);
        @(negedge mclk);
        last = rsp;
        req <= '{valid: 1'b1, op: op, src: src, dst: dst, srcb: srcb, to_gpr: tg, to_mem: tm};
        mem_val <= md;
    endtask : go

    task automatic idle();
        @(negedge mclk);
        last = rsp;
        req <= '0;
    endtask : idle

    task automatic final_report();
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // the whole sequence needs under two hundred cycles
    initial
    begin
        #(40 * 5000);
        err_total++;
        final_report();
    end

    initial
    begin
        rst_n = 1'b0;
        req = '0;
        mem_val = '0;
        gpr_val = 32'h89ab_cdef;
        err_total = 0;
        tests_run = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_n <= 1'b1;
        check(rsp, '0);
        // each row loads its first operand, then runs the operation back to back
        foreach (rows[i])
        begin
            go(PSALU_MOVE_QUAD, PSALU_SRC_MEM, 3'h1, 3'h0, 1'b0, 1'b0, rows[i].a);
            go(rows[i].op, PSALU_SRC_MEM, 3'h1, 3'h0, 1'b0, 1'b0, rows[i].b);
            check(last, resp(rows[i].a, 1'b0, 1'b0));
            idle();
            check(last, resp(rows[i].exp, 1'b0, 1'b0));
        end
        go(PSALU_MOVE_QUAD, PSALU_SRC_MEM, 3'h4, 3'h0, 1'b0, 1'b0, vk);
        go(PSALU_MOVE_DWORD, PSALU_SRC_REG, 3'h4, 3'h0, 1'b1, 1'b0, 64'h0);
        check(last, resp(vk, 1'b0, 1'b0));
        go(PSALU_MOVE_QUAD, PSALU_SRC_REG, 3'h4, 3'h0, 1'b0, 1'b1, 64'h0);
        check(last, resp({32'h0, vk[31:0]}, 1'b1, 1'b0));
        go(PSALU_MOVE_DWORD, PSALU_SRC_GPR, 3'h5, 3'h0, 1'b0, 1'b0, 64'h0);
        check(last, resp(vk, 1'b0, 1'b1));
        go(PSALU_MOVE_QUAD, PSALU_SRC_REG, 3'h6, 3'h4, 1'b0, 1'b0, 64'h0);
        check(last, resp({32'h0, gpr_val}, 1'b0, 1'b0));
        check(resp(store, 1'b0, 1'b0), resp(vk, 1'b0, 1'b0));
        go(PSALU_NOP, PSALU_SRC_REG, 3'h4, 3'h0, 1'b0, 1'b0, 64'h0);
        check(last, resp(vk, 1'b0, 1'b0));
        go(PSALU_CLEAR, PSALU_SRC_REG, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0);
        check(last, resp(vk, 1'b0, 1'b0));
        go(PSALU_NOP, PSALU_SRC_REG, 3'h6, 3'h0, 1'b0, 1'b0, 64'h0);
        go(PSALU_NOP, PSALU_SRC_REG, 3'h5, 3'h0, 1'b0, 1'b0, 64'h0);
        check(last, resp(64'h0, 1'b0, 1'b0));
        go(PSALU_ADD_D, PSALU_SRC_GPR, 3'h5, 3'h0, 1'b0, 1'b0, 64'h0);
        check(last, resp(64'h0, 1'b0, 1'b0));
        go(PSALU_MOVE_QUAD, PSALU_SRC_MEM, 3'h7, 3'h0, 1'b0, 1'b0, vk);
        check(last, resp({32'h0, gpr_val}, 1'b0, 1'b0));
        idle();
        check(last, resp(vk, 1'b0, 1'b0));
        // reset in mid-run must empty the registers and silence the answer
        @(negedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(negedge mclk);
        check(rsp, '0);
        rst_n <= 1'b1;
        go(PSALU_NOP, PSALU_SRC_REG, 3'h7, 3'h0, 1'b0, 1'b0, 64'h0);
        idle();
        check(last, resp(64'h0, 1'b0, 1'b0));
        final_report();
    end
endmodule : tb
